// *** verilog/dspt_timer.sv ***
// 16-bit pwm timer with fast, phase correct and phase-freq modes
// Notes on behaviour
// - fast pwm: compare a buffered, loads at top
// - output field two non-inverted, three inverted
// - fast pwm: change on match, restore at wrap
// - zero gives spike; top gives constant level
// - mode 15 field 1: a toggles per match
// - modes 1,2,3,10,11 count up then down
// - dual slope: clear rising match, set falling
// - phase correct top: fixed, capture or a
// - dual slope reverses at top, held once
// - phase correct: overflow bottom, reload at top
// - channel flag sets when count equals compare
// - register top from two to sixteen bits
// - fixed top masks compare write high bits
// - phase correct period runs top to top
// - phase correct extremes give constant levels
// - mode 11 field 1: a toggles per match
// - modes 8, 9: phase-freq correct, top source
// - phase-freq: reload and overflow at bottom
// - pin driven only when direction is output
// - tick from clock divided 1..1024
// - fast pwm modes 5,6,7,14,15 and tops
// - fast pwm: overflow at top; top flag at top in mode 14 only
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

module dspt_timer (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire dspt_pkg::dspt_axi_req_s i_axi,
    output dspt_pkg::dspt_axi_rsp_s o_axi,
    output logic o_pin_a,
    output logic o_pin_a_oe,
    output logic o_pin_b,
    output logic o_pin_b_oe
);
    import dspt_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        dspt_axi_rsp_s rsp;
        logic aw_ok;
        logic [DSPT_AW-1:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [3:0] wmode;
        logic [1:0] om_a;
        logic [1:0] om_b;
        logic [2:0] csel;
        logic [PSC_W-1:0] psc;
        logic [15:0] cnt;
        logic up;
        logic [15:0] cmpa_buf;
        logic [15:0] cmpb_buf;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [15:0] capt;
        logic [3:0] flags;
        logic [1:0] dir;
        logic wave_a;
        logic wave_b;
        logic pin_a;
        logic pin_a_oe;
        logic pin_b;
        logic pin_b_oe;
    } dspt_st_s;

    dspt_st_s s_r;
    dspt_st_s s_nxt;

    // ************************************************************
    // helpers
    // ************************************************************

    // single-slope modes
    function automatic logic is_fast(input logic [3:0] m);
        is_fast = (m == WM_FAST8) || (m == WM_FAST9) ||
            (m == WM_FAST10) || (m == WM_FAST_CAPT) ||
            (m == WM_FAST_CMPA);
    endfunction : is_fast

    // phase correct modes
    function automatic logic is_pc(input logic [3:0] m);
        is_pc = (m == WM_PC8) || (m == WM_PC9) || (m == WM_PC10) ||
            (m == WM_PC_CAPT) || (m == WM_PC_CMPA);
    endfunction : is_pc

    // phase and frequency correct modes
    function automatic logic is_pfc(input logic [3:0] m);
        is_pfc = (m == WM_PFC_CAPT) || (m == WM_PFC_CMPA);
    endfunction : is_pfc

    // top from fixed value, capture or compare a
    function automatic logic [15:0] top_of(
        input logic [3:0] m,
        input logic [15:0] capt,
        input logic [15:0] cmpa
    );
        case (m)
            WM_PC8, WM_FAST8: top_of = TOP_8BIT;
            WM_PC9, WM_FAST9: top_of = TOP_9BIT;
            WM_PC10, WM_FAST10: top_of = TOP_10BIT;
            WM_PC_CAPT, WM_FAST_CAPT, WM_PFC_CAPT: top_of = capt;
            WM_PC_CMPA, WM_FAST_CMPA, WM_PFC_CMPA: top_of = cmpa;
            default: top_of = CNT_MAX;
        endcase
    endfunction : top_of

    // write mask: fixed tops keep only the resolution bits
    function automatic logic [15:0] mask_of(input logic [3:0] m);
        case (m)
            WM_PC8, WM_FAST8: mask_of = TOP_8BIT;
            WM_PC9, WM_FAST9: mask_of = TOP_9BIT;
            WM_PC10, WM_FAST10: mask_of = TOP_10BIT;
            default: mask_of = CNT_MAX;
        endcase
    endfunction : mask_of

    // prescaler terminal count per clock select
    function automatic logic [PSC_W-1:0] ps_last(input logic [2:0] c);
        case (c)
            CS_DIV8: ps_last = PS_LAST_8;
            CS_DIV64: ps_last = PS_LAST_64;
            CS_DIV256: ps_last = PS_LAST_256;
            CS_DIV1024: ps_last = PS_LAST_1024;
            default: ps_last = PS_LAST_1;
        endcase
    endfunction : ps_last

    // modes where channel a may toggle on match
    function automatic logic tog_mode(input logic [3:0] m);
        tog_mode = (m == WM_FAST_CMPA) || (m == WM_FAST_CAPT) ||
            (m == WM_PC_CMPA) || (m == WM_PFC_CMPA);
    endfunction : tog_mode

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0] strb
    );
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
    endfunction : merge

    // next waveform level; lvl is the non-inverted level on match
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] om,
        input logic hit,
        input logic lvl,
        input logic wrap,
        input logic tog_ok
    );
        logic pol;
        pol = (om == OM_INV);
        wave_next = cur;
        if (om == OM_TOGGLE) begin
            if (tog_ok && hit) begin
                wave_next = ~cur;
            end
        end else if (om != OM_OFF) begin
            if (wrap) begin
                wave_next = ~pol;
            end else if (hit) begin
                wave_next = lvl ^ pol;
            end
        end
    endfunction : wave_next

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic tick;
        logic [15:0] top;
        logic at_top;
        logic at_bot;
        logic hit_a;
        logic hit_b;
        logic down_ph;
        logic reload;
        logic [3:0] fset;
        logic [3:0] fclr;
        logic [31:0] wv;
        logic [15:0] cv;
        logic tog_a;
        tick = 1'b0;
        top = CNT_MAX;
        at_top = 1'b0;
        at_bot = 1'b0;
        hit_a = 1'b0;
        hit_b = 1'b0;
        down_ph = 1'b0;
        reload = 1'b0;
        fset = '0;
        fclr = '0;
        wv = '0;
        cv = '0;
        tog_a = 1'b0;
        s_nxt = s_r;

        // prescaler divides the clock into timer ticks
        tick = (s_r.csel != CS_STOP) && (s_r.psc == ps_last(s_r.csel));
        if (s_r.csel == CS_STOP || tick) begin
            s_nxt.psc = '0;
        end else begin
            s_nxt.psc = s_r.psc + PS_STEP;
        end

        // count position against top and compare values
        top = top_of(s_r.wmode, s_r.capt, s_r.cmpa);
        at_top = (s_r.cnt == top);
        at_bot = (s_r.cnt == CNT_BOTTOM);
        hit_a = (s_r.cnt == s_r.cmpa);
        hit_b = (s_r.cnt == s_r.cmpb);
        tog_a = tog_mode(s_r.wmode);

        if (tick) begin
            fset[FLG_CMPA] = hit_a;
            fset[FLG_CMPB] = hit_b;
            if (is_fast(s_r.wmode)) begin
                // single slope: bottom to top, then clear
                if (at_top) begin
                    s_nxt.cnt = CNT_BOTTOM;
                    fset[FLG_OVF] = 1'b1;
                    fset[FLG_CAPT] = (s_r.wmode == WM_FAST_CAPT);
                    reload = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + CNT_STEP;
                end
                s_nxt.wave_a = wave_next(s_r.wave_a, s_r.om_a, hit_a,
                    1'b0, at_top, tog_a);
                s_nxt.wave_b = wave_next(s_r.wave_b, s_r.om_b, hit_b,
                    1'b0, at_top, 1'b0);
            end else if (is_pc(s_r.wmode) || is_pfc(s_r.wmode)) begin
                // dual slope: turn at top and at bottom
                if (s_r.up) begin
                    if (at_top) begin
                        s_nxt.up = 1'b0;
                        s_nxt.cnt = s_r.cnt - CNT_STEP;
                    end else begin
                        s_nxt.cnt = s_r.cnt + CNT_STEP;
                    end
                end else begin
                    if (at_bot) begin
                        s_nxt.up = 1'b1;
                        s_nxt.cnt = s_r.cnt + CNT_STEP;
                    end else begin
                        s_nxt.cnt = s_r.cnt - CNT_STEP;
                    end
                end
                // turn at top: phase correct reloads here
                if (s_r.up && at_top) begin
                    fset[FLG_CAPT] = (s_r.wmode == WM_PC_CAPT) ||
                        (s_r.wmode == WM_PFC_CAPT);
                    reload = is_pc(s_r.wmode);
                end
                // turn at bottom: overflow, phase-freq reloads
                if (!s_r.up && at_bot) begin
                    fset[FLG_OVF] = 1'b1;
                    reload = is_pfc(s_r.wmode);
                end
                // falling phase; the extremes pin the levels
                down_ph = at_top || (!at_bot && !s_r.up);
                s_nxt.wave_a = wave_next(s_r.wave_a, s_r.om_a, hit_a,
                    down_ph, 1'b0, tog_a);
                s_nxt.wave_b = wave_next(s_r.wave_b, s_r.om_b, hit_b,
                    down_ph, 1'b0, 1'b0);
            end else begin
                // other modes: free count, outputs held
                s_nxt.cnt = s_r.cnt + CNT_STEP;
                fset[FLG_OVF] = (s_r.cnt == CNT_MAX);
            end
        end

        // active compare values take the buffered ones
        if (reload) begin
            s_nxt.cmpa = s_r.cmpa_buf;
            s_nxt.cmpb = s_r.cmpb_buf;
        end

        // ********************************************************
        // bus write channel
        // ********************************************************
        if (i_axi.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && s_r.rsp.wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = i_axi.wdata;
            s_nxt.wstrb = i_axi.wstrb;
        end
        if (s_r.rsp.bvalid && i_axi.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end

        // perform a write once address and data are both held
        if (s_r.aw_ok && s_r.w_ok && !s_r.rsp.bvalid) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = RESP_OKAY;
            case (s_r.awaddr)
                OFS_CTRL: begin
                    wv = merge({21'h000000, s_r.csel, s_r.om_b,
                        s_r.om_a, s_r.wmode}, s_r.wdata, s_r.wstrb);
                    s_nxt.wmode = wv[CTRL_MODE_LSB +: 4];
                    s_nxt.om_a = wv[CTRL_OMA_LSB +: 2];
                    s_nxt.om_b = wv[CTRL_OMB_LSB +: 2];
                    s_nxt.csel = wv[CTRL_CS_LSB +: 3];
                end
                OFS_COUNT: begin
                    // count reads only; the write is accepted
                end
                OFS_CMPA: begin
                    wv = merge(32'(s_r.cmpa_buf), s_r.wdata, s_r.wstrb);
                    cv = wv[15:0] & mask_of(s_r.wmode);
                    s_nxt.cmpa_buf = cv;
                    if (!is_fast(s_r.wmode) && !is_pc(s_r.wmode) &&
                        !is_pfc(s_r.wmode)) begin
                        s_nxt.cmpa = cv;
                    end
                end
                OFS_CMPB: begin
                    wv = merge(32'(s_r.cmpb_buf), s_r.wdata, s_r.wstrb);
                    cv = wv[15:0] & mask_of(s_r.wmode);
                    s_nxt.cmpb_buf = cv;
                    if (!is_fast(s_r.wmode) && !is_pc(s_r.wmode) &&
                        !is_pfc(s_r.wmode)) begin
                        s_nxt.cmpb = cv;
                    end
                end
                OFS_CAPT: begin
                    wv = merge(32'(s_r.capt), s_r.wdata, s_r.wstrb);
                    s_nxt.capt = wv[15:0];
                end
                OFS_FLAGS: begin
                    fclr = s_r.wdata[3:0] & {4{s_r.wstrb[0]}};
                end
                OFS_PINDIR: begin
                    wv = merge(32'(s_r.dir), s_r.wdata, s_r.wstrb);
                    s_nxt.dir = wv[1:0];
                end
                default: begin
                    s_nxt.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        s_nxt.rsp.awready = !s_nxt.aw_ok;
        s_nxt.rsp.wready = !s_nxt.w_ok;

        // flags: write one clears, a same-cycle set wins
        s_nxt.flags = (s_r.flags & ~fclr) | fset;

        // ********************************************************
        // bus read channel
        // ********************************************************
        if (s_r.rsp.rvalid && i_axi.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
        end
        if (i_axi.arvalid && s_r.rsp.arready) begin
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rresp = RESP_OKAY;
            case (i_axi.araddr)
                OFS_CTRL: s_nxt.rsp.rdata = {21'h000000, s_r.csel,
                    s_r.om_b, s_r.om_a, s_r.wmode};
                OFS_COUNT: s_nxt.rsp.rdata = 32'(s_r.cnt);
                OFS_CMPA: s_nxt.rsp.rdata = 32'(s_r.cmpa_buf);
                OFS_CMPB: s_nxt.rsp.rdata = 32'(s_r.cmpb_buf);
                OFS_CAPT: s_nxt.rsp.rdata = 32'(s_r.capt);
                OFS_FLAGS: s_nxt.rsp.rdata = 32'(s_r.flags);
                OFS_PINDIR: s_nxt.rsp.rdata = 32'(s_r.dir);
                default: begin
                    s_nxt.rsp.rdata = '0;
                    s_nxt.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

        // ********************************************************
        // pins follow the waveform while enabled as outputs
        // ********************************************************
        s_nxt.pin_a = s_nxt.wave_a;
        s_nxt.pin_b = s_nxt.wave_b;
        s_nxt.pin_a_oe = s_nxt.dir[0] && (s_nxt.om_a != OM_OFF) &&
            ((s_nxt.om_a != OM_TOGGLE) || tog_mode(s_nxt.wmode));
        s_nxt.pin_b_oe = s_nxt.dir[1] && (s_nxt.om_b != OM_OFF) &&
            (s_nxt.om_b != OM_TOGGLE);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r <= '0;
            s_r.up <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign o_axi = s_r.rsp;
    assign o_pin_a = s_r.pin_a;
    assign o_pin_a_oe = s_r.pin_a_oe;
    assign o_pin_b = s_r.pin_b;
    assign o_pin_b_oe = s_r.pin_b_oe;

endmodule : dspt_timer

// *** pkg/dspt_pkg.sv ***
// package of constants and carriers for the dual-slope pwm timer
package dspt_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned DSPT_AW = 5;
    localparam logic [DSPT_AW-1:0] OFS_CTRL = 5'h00;
    localparam logic [DSPT_AW-1:0] OFS_COUNT = 5'h04;
    localparam logic [DSPT_AW-1:0] OFS_CMPA = 5'h08;
    localparam logic [DSPT_AW-1:0] OFS_CMPB = 5'h0c;
    localparam logic [DSPT_AW-1:0] OFS_CAPT = 5'h10;
    localparam logic [DSPT_AW-1:0] OFS_FLAGS = 5'h14;
    localparam logic [DSPT_AW-1:0] OFS_PINDIR = 5'h18;

    // control word fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_OMA_LSB = 4;
    localparam int unsigned CTRL_OMB_LSB = 6;
    localparam int unsigned CTRL_CS_LSB = 8;

    // flag bits
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_CMPA = 1;
    localparam int unsigned FLG_CMPB = 2;
    localparam int unsigned FLG_CAPT = 3;

    // ************************************************************
    // waveform modes
    // ************************************************************
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_FAST8 = 4'h5;
    localparam logic [3:0] WM_FAST9 = 4'h6;
    localparam logic [3:0] WM_FAST10 = 4'h7;
    localparam logic [3:0] WM_PFC_CAPT = 4'h8;
    localparam logic [3:0] WM_PFC_CMPA = 4'h9;
    localparam logic [3:0] WM_PC_CAPT = 4'ha;
    localparam logic [3:0] WM_PC_CMPA = 4'hb;
    localparam logic [3:0] WM_FAST_CAPT = 4'he;
    localparam logic [3:0] WM_FAST_CMPA = 4'hf;

    // fixed top values and bounds
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // output mode field codes
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_NONINV = 2'h2;
    localparam logic [1:0] OM_INV = 2'h3;

    // ************************************************************
    // prescaler: select codes and terminal counts (divisor - 1)
    // ************************************************************
    localparam int unsigned PSC_W = 10;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [PSC_W-1:0] PS_LAST_1 = 10'h000;
    localparam logic [PSC_W-1:0] PS_LAST_8 = 10'h007;
    localparam logic [PSC_W-1:0] PS_LAST_64 = 10'h03f;
    localparam logic [PSC_W-1:0] PS_LAST_256 = 10'h0ff;
    localparam logic [PSC_W-1:0] PS_LAST_1024 = 10'h3ff;
    localparam logic [PSC_W-1:0] PS_STEP = 10'h001;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // bus carriers
    // ************************************************************
    typedef struct packed {
        logic awvalid;
        logic [DSPT_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [DSPT_AW-1:0] araddr;
        logic rready;
    } dspt_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dspt_axi_rsp_s;

endpackage : dspt_pkg

// *** test/dspt_load.sv ***
// pin load model standing on the compare output pads
`timescale 1ns/1ps

module dspt_load (
    input wire logic i_pin,
    input wire logic i_oe,
    output logic o_lvl
);
    // ********
    // pad level
    // ********
    // a released pad falls to the pull-down level, never the last value
    assign o_lvl = i_oe ? i_pin : 1'b0;
endmodule : dspt_load

// *** test/dspt_timer_props.sv ***
// concurrent checks on the pwm timer's ports
`timescale 1ns/1ps

module dspt_timer_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire dspt_pkg::dspt_axi_req_s i_axi,
    input wire dspt_pkg::dspt_axi_rsp_s o_axi,
    input wire logic o_pin_a,
    input wire logic o_pin_a_oe,
    input wire logic o_pin_b,
    input wire logic o_pin_b_oe
);
    import dspt_pkg::*;
    // ********
    // bus answers and pin enables
    // ********
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    rst_clear_a: assert property (
        $past(i_sys_rst) |-> !o_pin_a && !o_pin_b && !o_pin_a_oe
            && !o_pin_b_oe && !o_axi.bvalid && !o_axi.rvalid)
        else $error("outputs not clear after reset");
    oe_a_cause_a: assert property (
        $changed(o_pin_a_oe) |-> o_axi.bvalid || $past(o_axi.bvalid))
        else $error("pin a enable moved without a write");
    oe_b_cause_a: assert property (
        $changed(o_pin_b_oe) |-> o_axi.bvalid || $past(o_axi.bvalid))
        else $error("pin b enable moved without a write");
    rd_latency_a: assert property (
        i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
        else $error("read data late");
    ar_busy_a: assert property (o_axi.rvalid |-> !o_axi.arready)
        else $error("read address open during answer");
    wr_latency_a: assert property (
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
            |=> !o_axi.bvalid ##1 o_axi.bvalid)
        else $error("write answer not two cycles after take");
    wr_busy_a: assert property (
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
            |=> !o_axi.awready ##1 o_axi.awready)
        else $error("write address not reopened after perform");
    b_single_a: assert property (
        o_axi.bvalid && i_axi.bready |=> !o_axi.bvalid)
        else $error("write answer held after accept");
    err_data_a: assert property (
        o_axi.rvalid && o_axi.rresp == RESP_SLVERR |-> o_axi.rdata == 32'h0)
        else $error("refused read returned data");
endmodule : dspt_timer_props

bind dspt_timer dspt_timer_props u_props (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_axi(i_axi), .o_axi(o_axi),
    .o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b),
    .o_pin_b_oe(o_pin_b_oe));

// *** test/tb_dspt_timer.sv ***
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps

module tb_dspt_timer;
    import dspt_pkg::*;
    // ********
    // rows: mode, {om b, om a}, clock select, pin dir, cmp a, cmp b,
    // capture, window, high cycles a and b in window, flags
    // ********
    typedef struct packed {
        logic [3:0] md, om, cs, dir;
        logic [15:0] ca, cb, cap, w, ha, hb;
        logic [3:0] fl;
    } dspt_row_s;
    dspt_row_s rows [16] = '{
        116'hee13_0000_000c_0009_000a_0001_0000_b,
        116'hf913_0005_0002_0000_000c_0006_0006_7,
        116'hae13_0003_0008_0008_0010_0006_0000_f,
        116'hb913_0004_0000_0000_0010_0008_0000_7,
        116'h8b13_0002_0005_0006_000c_0008_000a_f,
        116'h9913_0003_0001_0000_000c_0006_0004_7,
        116'h5e13_007f_00ff_0000_0100_0080_0000_7,
        116'h6b13_01ff_0000_0000_0200_0000_0001_7,
        116'h7e13_03ff_0100_0000_0400_0400_02ff_7,
        116'h1e13_0040_0080_0000_01fe_0080_00fe_7,
        116'h2a11_0100_0001_0000_03fe_0200_0000_7,
        116'h3a13_03ff_0000_0000_07fe_07fe_0000_7,
        116'hee23_0001_0001_0003_0020_0010_0010_f,
        116'hee33_0001_0001_0003_0100_0080_0080_f,
        116'hee43_0001_0001_0003_0400_0200_0200_f,
        116'hee53_0001_0001_0003_1000_0800_0800_f};
    logic i_clk, i_sys_rst, pa, pa_oe, pb, pb_oe, lvl_a, lvl_b;
    dspt_axi_req_s req;
    dspt_axi_rsp_s rsp;
    dspt_row_s r;
    logic [31:0] rdv;
    logic [1:0] rs;
    int n_errors, n_checks, k, ha, hb;

    dspt_timer u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_axi(req),
        .o_axi(rsp), .o_pin_a(pa), .o_pin_a_oe(pa_oe), .o_pin_b(pb),
        .o_pin_b_oe(pb_oe));
    dspt_load u_load_a (.i_pin(pa), .i_oe(pa_oe), .o_lvl(lvl_a));
    dspt_load u_load_b (.i_pin(pb), .i_oe(pb_oe), .o_lvl(lvl_b));

    // ********
    // clock, verdict and bus tasks
    // ********
    always #12.5 i_clk = ~i_clk;

    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // a bus wait that runs out ends the run
    task automatic tmo(input int i);
        if (i == 50) begin
            chk("bus answer", 32'h0, 32'h1);
            conclude();
        end
    endtask : tmo

    task automatic rst(input int n);
        i_sys_rst <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
    endtask : rst

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int i;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge i_clk);
            if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
            if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        rs = rsp.bresp;
        tmo(i);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        int i;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        for (i = 0; i < 50; i++) begin
            @(posedge i_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rdv = rsp.rdata;
        rs = rsp.rresp;
        tmo(i);
    endtask : rd

    // ********
    // main sequence: table rows, then reset and refusal cases
    // ********
    initial begin
        i_clk = 1'b0;
        i_sys_rst = 1'b1;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        rst(8);
        for (k = 0; k < 16; k++) begin
            r = rows[k];
            rst(2);
            wr(OFS_CMPA, {16'h0, r.ca});
            wr(OFS_CMPB, {16'h0, r.cb});
            wr(OFS_CAPT, {16'h0, r.cap});
            wr(OFS_PINDIR, {28'h0, r.dir});
            wr(OFS_CTRL, {21'h0, r.cs[2:0], r.om, r.md});
            repeat (r.w) @(posedge i_clk);
            ha = 0;
            hb = 0;
            repeat (r.w) begin
                @(posedge i_clk);
                ha += lvl_a;
                hb += lvl_b;
            end
            chk("high a", ha, r.ha);
            chk("high b", hb, r.hb);
            rd(OFS_FLAGS);
            chk("flags", rdv, {28'h0, r.fl});
        end
        // rows also
        rst(2);
        rd(OFS_COUNT);
        chk("count", rdv, 32'h0);
        rd(OFS_FLAGS);
        chk("flags", rdv, 32'h0);
        wr(OFS_CTRL, {28'h0, WM_FAST9});
        wr(OFS_CMPA, 32'hffff);
        rd(OFS_CMPA);
        chk("masked cmp", rdv, {16'h0, TOP_9BIT});
        // active compares stay zero until top, so both match at once
        wr(OFS_CTRL, {21'h0, CS_DIV1, 4'h0, WM_FAST9});
        rd(OFS_FLAGS);
        chk("buffered cmp", rdv, 32'h6);
        rd(5'h1c);
        chk("bad rd resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        chk("bad rd data", rdv, 32'h0);
        wr(5'h1c, 32'h1);
        chk("bad wr resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        conclude();
    end
endmodule : tb_dspt_timer
